// *** logic/ubs_top.sv ***
// usb bus-state, remote wake-up and endpoint interrupt-enable logic
// assumes engine inputs synchronous to core_clk_i; 8-bit register port
//
// Behaviour
// R1 - per-endpoint interrupt enables, bits 0-3, reset 0
// R2 - enable register bits 4-7 read zero
// R3 - suspend indicator bit 0, read-only, reset 0
// R4 - suspend rising edge raises usb interrupt
// R5 - software sets bit 1 to wake host
// R6 - bus reset flag follows engine, interrupts on set
// R7 - resume indicator bit 3, set interrupts
// R8 - resume clears when suspend returns zero
// R9 - software enables usb clock, clears deep suspend; not implemented here, no clock-enable or deep-suspend bit exists
// R10 - bit 4 switches 3.3 V regulator, reset 0
// R11 - bit 5 one powers pll down
// R12 - bit 6 selects ps/2 mode, reset 0
// R13 - bit 7 lets bus reset reset cpu
// R14 - suspend after more than 3 ms idle
// R15 - endpoint access sets request flag, interrupt
// R16 - request interrupts only when endpoint enabled
//
// Our own choices: the address map and the address-and-strobe port.
module ubs_top #(
    parameter int unsigned IDLE_CYCLES = ubs_pkg::IDLE_CYC,
    parameter int unsigned WAKE_CYCLES = ubs_pkg::WAKE_CYC
) (
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    // register port
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    // serial interface engine side
    input  wire logic       bus_activity_i,
    input  wire logic       bus_reset_det_i,
    input  wire logic [3:0] ep_access_i,
    // controls and indications
    output logic            usb_irq_o,
    output logic            remote_wake_drive_o,
    output logic            regulator_3v3_output_on_o,
    output logic            pll_power_down_o,
    output logic            ps2_mode_select_o,
    output logic            cpu_reset_req_o,
    output logic            bus_suspended_o
);

    // refuse an idle limit of zero cycles
    initial begin
        if (IDLE_CYCLES < 1 || WAKE_CYCLES < 1) begin
            $error("idle and wake counts must be at least one");
        end
    end

    // sticky write-one-to-clear update; a set in the same cycle wins
    function automatic logic [3:0] w1c(
        input logic [3:0] cur,
        input logic [3:0] set,
        input logic [3:0] clr
    );
        w1c = (cur & ~clr) | set;
    endfunction

    ubs_pkg::ubs_state_t state_reg;   // all registered state
    ubs_pkg::ubs_state_t state_next;  // next value of it

    logic idle;        // quiet-bus limit reached
    logic wake_busy;   // remote wake drive active
    logic wake_start;  // one-cycle start strobe

    // events seen this cycle
    logic       ev_bus_suspended_flag;
    logic       ev_resume;
    logic       ev_rst;
    logic [3:0] ep_set;
    logic       ev_ep;
    logic [3:0] is_set;
    logic       wr_ep_en;
    logic       wr_bs;
    logic       wr_ists;
    logic       wr_mask;
    logic       wr_epreq;
    logic       resume_end;

    // quiet-bus timer for suspend detection
    ubs_idle_timer #(
        .CYCLES (IDLE_CYCLES)
    ) u_idle (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .activity_i (bus_activity_i),
        .idle_o     (idle)
    );

    // wake pulse toward the host
    ubs_wake_pulse #(
        .CYCLES (WAKE_CYCLES)
    ) u_wake (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .start_i    (wake_start),
        .drive_o    (wake_busy)
    );

    // write decode
    always_comb begin
        wr_ep_en = wr_i && (addr_i == ubs_pkg::ADDR_EP_IRQ_EN);
        wr_bs    = wr_i && (addr_i == ubs_pkg::ADDR_BUS_STAT);
        wr_ists  = wr_i && (addr_i == ubs_pkg::ADDR_IRQ_STATUS);
        wr_mask  = wr_i && (addr_i == ubs_pkg::ADDR_IRQ_MASK);
        wr_epreq = wr_i && (addr_i == ubs_pkg::ADDR_EP_REQ);
        // software wake request starts the drive pulse
        wake_start = wr_bs && wdata_i[ubs_pkg::BS_WAKE];  // [R5]
    end

    // event detection
    always_comb begin
        // enter suspend once idle past the limit
        ev_bus_suspended_flag = idle && !state_reg.bus_suspended_flag;  // [R14]
        // first activity while suspended is the host resume
        ev_resume = state_reg.bus_suspended_flag && !state_reg.resume
                    && bus_activity_i;  // [R7]
        // resume signalling ends: bus falls quiet again
        resume_end = state_reg.bus_suspended_flag && state_reg.resume
                     && state_reg.act_d && !bus_activity_i;
        // rising edge of engine bus-reset detection
        ev_rst = bus_reset_det_i && !state_reg.rst_flag;  // [R6]
        // endpoint access sets its flag
        ep_set = ep_access_i;  // [R15]
        // only enabled endpoints raise the interrupt
        ev_ep = |(ep_access_i & state_reg.ep_en);  // [R16]
        is_set = '0;
        is_set[ubs_pkg::IS_BUS_SUSPENDED_FLAG]   = ev_bus_suspended_flag;  // [R4]
        is_set[ubs_pkg::IS_RST]    = ev_rst;  // [R6]
        is_set[ubs_pkg::IS_RESUME] = ev_resume;  // [R7]
        is_set[ubs_pkg::IS_EP]     = ev_ep;  // [R15]
    end

    // next-state logic
    always_comb begin
        state_next = state_reg;
        state_next.act_d = bus_activity_i;

        // endpoint enables, upper bits are not stored
        if (wr_ep_en) begin
            state_next.ep_en = wdata_i[3:0];  // [R1]
        end

        // writable control bits of the bus status register
        if (wr_bs) begin
            state_next.v33     = wdata_i[ubs_pkg::BS_V33];  // [R10]
            state_next.pll_off = wdata_i[ubs_pkg::BS_PLL];  // [R11]
            state_next.ps2     = wdata_i[ubs_pkg::BS_PS2];  // [R12]
            state_next.bus_reset_resets_cpu     = wdata_i[ubs_pkg::BS_URD];  // [R13]
        end

        // suspend set by idle, cleared when resume signalling ends
        if (ev_bus_suspended_flag) begin
            state_next.bus_suspended_flag = 1'b1;  // [R3]
        end else if (resume_end) begin
            state_next.bus_suspended_flag = 1'b0;  // [R3]
        end

        // resume cleared in the same edge that suspend drops
        if (ev_resume) begin
            state_next.resume = 1'b1;  // [R7]
        end else if (resume_end) begin
            state_next.resume = 1'b0;  // [R8]
        end

        // bus reset flag tracks the engine; software writes ignored
        state_next.rst_flag = bus_reset_det_i;  // [R6]

        // request flags, software clears by writing one
        state_next.ep_req = w1c(state_reg.ep_req, ep_set,
                                wr_epreq ? wdata_i[3:0] : 4'h0);  // [R15]

        // sticky interrupt status, write one to clear
        state_next.ists = w1c(state_reg.ists, is_set,
                              wr_ists ? wdata_i[3:0] : 4'h0);
        if (wr_mask) begin
            state_next.imask = wdata_i[3:0];
        end

        // level interrupt while any unmasked status bit is set
        state_next.irq = |(state_next.ists & state_next.imask);  // [R4]

        // bus reset resets the processor only when allowed
        state_next.cpu_rst = state_next.rst_flag && state_next.bus_reset_resets_cpu;  // [R13]

        // read data, valid the cycle after the read strobe
        state_next.rdata = ubs_pkg::RDATA_UNMAPPED;
        if (rd_i) begin
            case (addr_i)
                ubs_pkg::ADDR_EP_IRQ_EN: begin
                    // bits 4-7 have no storage and read zero
                    state_next.rdata = {4'h0, state_reg.ep_en};  // [R2]
                end
                ubs_pkg::ADDR_BUS_STAT: begin
                    state_next.rdata = {state_reg.bus_reset_resets_cpu,
                                        state_reg.ps2,
                                        state_reg.pll_off,
                                        state_reg.v33,
                                        state_reg.resume,
                                        state_reg.rst_flag,
                                        wake_busy,
                                        state_reg.bus_suspended_flag};  // [R3]
                end
                ubs_pkg::ADDR_IRQ_STATUS: begin
                    state_next.rdata = {4'h0, state_reg.ists};
                end
                ubs_pkg::ADDR_IRQ_MASK: begin
                    state_next.rdata = {4'h0, state_reg.imask};
                end
                ubs_pkg::ADDR_EP_REQ: begin
                    state_next.rdata = {4'h0, state_reg.ep_req};
                end
                default: begin
                    // unmapped address reads as zero
                    state_next.rdata = ubs_pkg::RDATA_UNMAPPED;
                end
            endcase
        end
    end

    // state register with reset values
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg          <= '0;
            state_reg.ep_en    <= ubs_pkg::EP_EN_RST;  // [R1]
            state_reg.imask    <= ubs_pkg::IMASK_RST;
            state_reg.bus_reset_resets_cpu      <= ubs_pkg::URD_RST;  // [R13]
            state_reg.rdata    <= ubs_pkg::RDATA_UNMAPPED;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from flip-flops
    assign rdata_o                   = state_reg.rdata;
    assign usb_irq_o                 = state_reg.irq;
    assign remote_wake_drive_o       = wake_busy;  // [R5]
    assign regulator_3v3_output_on_o = state_reg.v33;  // [R10]
    assign pll_power_down_o          = state_reg.pll_off;  // [R11]
    assign ps2_mode_select_o         = state_reg.ps2;  // [R12]
    assign cpu_reset_req_o           = state_reg.cpu_rst;
    assign bus_suspended_o           = state_reg.bus_suspended_flag;

endmodule // ubs_top

// *** logic/ubs_pkg.sv ***
// package for the usb bus-state and endpoint interrupt-enable block
// assumes a single 40 MHz core clock and an 8-bit register port
package ubs_pkg;

    // clock rate in MHz
    localparam int unsigned CLK_MHZ        = 40;
    // bus idle time before suspend, in microseconds
    localparam int unsigned IDLE_TIME_US   = 3000;
    // idle count: least time, rounds up (exact at 40 MHz)
    localparam int unsigned IDLE_CYC       = IDLE_TIME_US * CLK_MHZ;
    // remote wake-up drive length, in microseconds
    localparam int unsigned WAKE_TIME_US   = 5000;
    // wake count: longest time, rounds down
    localparam int unsigned WAKE_CYC       = WAKE_TIME_US * CLK_MHZ;

    // register indices on the 3-bit address port
    localparam logic [2:0] ADDR_EP_IRQ_EN  = 3'h0;
    localparam logic [2:0] ADDR_BUS_STAT   = 3'h1;
    localparam logic [2:0] ADDR_IRQ_STATUS = 3'h2;
    localparam logic [2:0] ADDR_IRQ_MASK   = 3'h3;
    localparam logic [2:0] ADDR_EP_REQ     = 3'h4;

    // bus status/control bit positions
    localparam int unsigned BS_BUS_SUSPENDED_FLAG        = 0;
    localparam int unsigned BS_WAKE        = 1;
    localparam int unsigned BS_RST         = 2;
    localparam int unsigned BS_RESUME      = 3;
    localparam int unsigned BS_V33         = 4;
    localparam int unsigned BS_PLL         = 5;
    localparam int unsigned BS_PS2         = 6;
    localparam int unsigned BS_URD         = 7;

    // interrupt status bit positions
    localparam int unsigned IS_BUS_SUSPENDED_FLAG        = 0;
    localparam int unsigned IS_RST         = 1;
    localparam int unsigned IS_RESUME      = 2;
    localparam int unsigned IS_EP          = 3;

    // reset values
    localparam logic [3:0] EP_EN_RST       = 4'h0;
    localparam logic [3:0] IMASK_RST       = 4'hF;
    localparam logic       URD_RST         = 1'b1;
    localparam logic [7:0] RDATA_UNMAPPED  = 8'h00;

    // whole state of the top module
    typedef struct packed {
        logic [3:0] ep_en;     // per-endpoint interrupt enables
        logic       bus_suspended_flag;      // bus_suspended_flag
        logic       resume;    // resume indicator
        logic       rst_flag;  // bus_reset_flag
        logic       v33;       // regulator_3v3_output_on
        logic       pll_off;   // pll power-down
        logic       ps2;       // ps2_mode_select
        logic       bus_reset_resets_cpu;       // bus_reset_resets_cpu
        logic [3:0] ep_req;    // endpoint request flags
        logic [3:0] ists;      // sticky interrupt status
        logic [3:0] imask;     // interrupt mask, 1 = pass
        logic [7:0] rdata;     // read data register
        logic       irq;       // interrupt output register
        logic       cpu_rst;   // processor reset request
        logic       act_d;     // activity, one cycle late
    } ubs_state_t;

endpackage

// *** logic/ubs_idle_timer.sv ***
// idle-bus timer: flags when the bus has been quiet too long
// assumes activity input is synchronous to core_clk_i
module ubs_idle_timer #(
    parameter int unsigned CYCLES = ubs_pkg::IDLE_CYC
) (
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    input  wire logic activity_i,
    output logic      idle_o
);
    localparam int unsigned CW = $clog2(CYCLES + 1);

    // refuse a count the counter cannot serve
    initial begin
        if (CYCLES < 1) begin
            $error("idle timer needs at least one cycle");
        end
    end

    logic [CW-1:0] cnt_reg;   // quiet cycles so far
    logic          idle_reg;  // quiet longer than the limit

    // count quiet cycles, restart on any activity
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg  <= '0;
            idle_reg <= 1'b0;
        end else if (activity_i) begin
            cnt_reg  <= '0;
            idle_reg <= 1'b0;
        end else if (cnt_reg == CW'(CYCLES)) begin
            // saturate so a long idle does not wrap
            idle_reg <= 1'b1;
        end else begin
            cnt_reg  <= cnt_reg + CW'(1);
        end
    end

    assign idle_o = idle_reg;
endmodule // ubs_idle_timer

// *** logic/ubs_wake_pulse.sv ***
// remote wake-up pulse generator: holds the drive for a fixed time
// assumes start_i is a one-cycle strobe from the register port
module ubs_wake_pulse #(
    parameter int unsigned CYCLES = ubs_pkg::WAKE_CYC
) (
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    input  wire logic start_i,
    output logic      drive_o
);
    localparam int unsigned CW = $clog2(CYCLES + 1);

    // refuse a zero-length pulse
    initial begin
        if (CYCLES < 1) begin
            $error("wake pulse needs at least one cycle");
        end
    end

    logic [CW-1:0] cnt_reg;    // cycles left to drive
    logic          drive_reg;  // drive active

    // a start while busy is ignored, pulse length stays fixed
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg   <= '0;
            drive_reg <= 1'b0;
        end else if (start_i && !drive_reg) begin
            cnt_reg   <= CW'(CYCLES - 1);
            drive_reg <= 1'b1;
        end else if (drive_reg) begin
            if (cnt_reg == '0) begin
                drive_reg <= 1'b0;
            end else begin
                cnt_reg <= cnt_reg - CW'(1);
            end
        end
    end

    assign drive_o = drive_reg;
endmodule // ubs_wake_pulse

// *** dv/ubs_assertions.sv ***
// port checks for the usb bus-state block
// assumes one clock domain; bound to ubs_top below
module ubs_assertions #(
    parameter int unsigned IDLE_CYCLES = 50,
    parameter int unsigned WAKE_CYCLES = 20
) (
    input wire logic       core_clk_i,
    input wire logic       rst_n_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       bus_activity_i,
    input wire logic       bus_reset_det_i,
    input wire logic       usb_irq_o,
    input wire logic       remote_wake_drive_o,
    input wire logic       regulator_3v3_output_on_o,
    input wire logic       pll_power_down_o,
    input wire logic       ps2_mode_select_o,
    input wire logic       cpu_reset_req_o,
    input wire logic       bus_suspended_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    ep_pad_zero_a: assert property (
        $past(rd_i) && $past(addr_i) == ubs_pkg::ADDR_EP_IRQ_EN |-> rdata_o[7:4] == 4'h0)
        else $error("enable pad bits read nonzero");
    bus_suspended_flag_read_a: assert property (
        $past(rd_i) && $past(addr_i) == ubs_pkg::ADDR_BUS_STAT
        |-> rdata_o[0] == $past(bus_suspended_o)) else $error("suspend bit misread");
    bus_suspended_flag_irq_a: assert property ($rose(bus_suspended_o) |-> usb_irq_o)
        else $error("suspend entry without interrupt");
    wake_hold_a: assert property (
        wr_i && addr_i == ubs_pkg::ADDR_BUS_STAT && wdata_i[1] && !remote_wake_drive_o
        |=> remote_wake_drive_o [*8]) else $error("wake drive too short");
    rst_irq_a: assert property ($rose(bus_reset_det_i) |=> usb_irq_o)
        else $error("bus reset without interrupt");
    cpu_rst_quiet_a: assert property (!$past(bus_reset_det_i) |-> !cpu_reset_req_o)
        else $error("cpu reset without bus reset");
    ctrl_follow_a: assert property (
        wr_i && addr_i == ubs_pkg::ADDR_BUS_STAT |=> {ps2_mode_select_o,
        pll_power_down_o, regulator_3v3_output_on_o} == $past(wdata_i[6:4]))
        else $error("control outputs do not follow write");
    ctrl_hold_a: assert property (
        !(wr_i && addr_i == ubs_pkg::ADDR_BUS_STAT) |=> $stable({ps2_mode_select_o,
        pll_power_down_o, regulator_3v3_output_on_o})) else $error("control outputs drift");
    no_early_bus_suspended_flag_a: assert property (
        !bus_suspended_o && bus_activity_i |=> !bus_suspended_o)
        else $error("suspend entered on an active bus");
    resume_exit_a: assert property (
        bus_suspended_o && $past(bus_activity_i, 2) && $past(bus_activity_i) && !bus_activity_i
        |=> !bus_suspended_o) else $error("suspend not left after resume");
endmodule // ubs_assertions

bind ubs_top ubs_assertions #(
    .IDLE_CYCLES(IDLE_CYCLES),
    .WAKE_CYCLES(WAKE_CYCLES)
) u_ubs_assertions (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .bus_activity_i(bus_activity_i),
    .bus_reset_det_i(bus_reset_det_i), .usb_irq_o(usb_irq_o),
    .remote_wake_drive_o(remote_wake_drive_o),
    .regulator_3v3_output_on_o(regulator_3v3_output_on_o),
    .pll_power_down_o(pll_power_down_o), .ps2_mode_select_o(ps2_mode_select_o),
    .cpu_reset_req_o(cpu_reset_req_o), .bus_suspended_o(bus_suspended_o)
);

// *** dv/ubs_host_model.sv ***
// host seen through the engine: bus traffic, bus reset, endpoint hits
// assumes commands from the bench, synchronous to core_clk_i
module ubs_host_model (
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       quiet_i,     // host stops all traffic
    input  wire logic       bus_rst_i,   // host drives bus reset
    input  wire logic [3:0] ep_hit_i,    // endpoint transactions to issue
    input  wire logic       wake_i,      // device wake drive on the bus
    output logic            activity_o,
    output logic            reset_det_o,
    output logic [3:0]      ep_access_o
);
    logic       wake_d;                  // wake drive, one cycle late
    logic [3:0] resume_cnt;              // resume signalling left

    // host answers the end of a wake drive with a resume burst
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_d      <= 1'b0;
            resume_cnt  <= 4'h0;
            activity_o  <= 1'b0;
            reset_det_o <= 1'b0;
            ep_access_o <= 4'h0;
        end else begin
            wake_d <= wake_i;
            if (wake_d && !wake_i) begin
                resume_cnt <= 4'h6;
            end else if (resume_cnt != 4'h0) begin
                resume_cnt <= resume_cnt - 4'h1;
            end
            activity_o  <= !quiet_i || (resume_cnt != 4'h0);
            reset_det_o <= bus_rst_i;
            // no endpoint traffic on a quiet bus
            ep_access_o <= quiet_i ? 4'h0 : ep_hit_i;
        end
    end
endmodule // ubs_host_model

// *** dv/tb.sv ***
// self-checking bench for the usb bus-state block
// assumes the host model on the engine side and short idle and wake counts
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int IDLE = 50;            // shortened quiet time
    localparam int WAKE = 20;            // shortened wake drive
    logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, rdata, d;
    logic       quiet = 1'b0, bus_rst = 1'b0, act, rdet, irq, wake, v33, pll, ps2, cpu_rst, bus_suspended_flag;
    logic [3:0] ep_hit = 4'h0, ep_acc, en;
    logic [31:0] rnd;                    // random stream state
    int         cnt, compares = 0, miscompares = 0;

    always #12.5 clk = ~clk;

    ubs_top #(.IDLE_CYCLES(IDLE), .WAKE_CYCLES(WAKE)) i_ubs_top (
        .core_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .bus_activity_i(act), .bus_reset_det_i(rdet),
        .ep_access_i(ep_acc), .usb_irq_o(irq), .remote_wake_drive_o(wake),
        .regulator_3v3_output_on_o(v33), .pll_power_down_o(pll), .ps2_mode_select_o(ps2),
        .cpu_reset_req_o(cpu_rst), .bus_suspended_o(bus_suspended_flag));
    ubs_host_model i_ubs_host_model (
        .core_clk_i(clk), .rst_n_i(rst_n), .quiet_i(quiet), .bus_rst_i(bus_rst),
        .ep_hit_i(ep_hit), .wake_i(wake), .activity_o(act), .reset_det_o(rdet),
        .ep_access_o(ep_acc));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic report_and_stop();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one-cycle bus strobes; settled outputs are sampled 1 ns after the edge
    task automatic wrr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic wait_bus_suspended_flag(input logic want, output int n);
        for (n = 0; n < 400 && bus_suspended_flag !== want; n++) begin @(posedge clk); #1; end
        if (n >= 400) begin
            chk({7'h0, bus_suspended_flag}, {7'h0, want});
            report_and_stop();
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    initial begin
        rnd = 32'hDBF3;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rdc(ubs_pkg::ADDR_EP_IRQ_EN, 8'h00);
        rdc(ubs_pkg::ADDR_BUS_STAT, 8'h80);
        wrr(3'h7, 8'hFF);
        rdc(3'h7, 8'h00);
        repeat (6) begin
            rnd = lfsr(rnd);
            wrr(ubs_pkg::ADDR_EP_IRQ_EN, rnd[7:0]);
            rdc(ubs_pkg::ADDR_EP_IRQ_EN, {4'h0, rnd[3:0]});
            d = rnd[15:8] & 8'hFD;
            wrr(ubs_pkg::ADDR_BUS_STAT, d);
            chk({5'h0, ps2, pll, v33}, {5'h0, d[6:4]});
            rdc(ubs_pkg::ADDR_BUS_STAT, {d[7:4], 4'h0});
        end
        $display("test registers done");
        for (int n = 0; n < 4; n++) begin
            rnd = lfsr(rnd);
            en = rnd[3:0];
            en[n] = n[0];
            wrr(ubs_pkg::ADDR_EP_IRQ_EN, {4'h0, en});
            @(posedge clk) ep_hit <= 4'h1 << n;
            @(posedge clk) ep_hit <= 4'h0;
            idle(3);
            chk({7'h0, irq}, {7'h0, en[n]});
            rdc(ubs_pkg::ADDR_EP_REQ, 8'h01 << n);
            rdc(ubs_pkg::ADDR_IRQ_STATUS, {4'h0, en[n], 3'h0});
            wrr(ubs_pkg::ADDR_IRQ_MASK, 8'h07);
            chk({7'h0, irq}, 8'h00);
            wrr(ubs_pkg::ADDR_IRQ_MASK, 8'h0F);
            wrr(ubs_pkg::ADDR_IRQ_STATUS, 8'h0F);
            wrr(ubs_pkg::ADDR_EP_REQ, 8'h0F);
            chk({7'h0, irq}, 8'h00);
        end
        $display("test endpoints done");
        for (int u = 1; u >= 0; u--) begin
            wrr(ubs_pkg::ADDR_BUS_STAT, {u[0], 7'h0});
            @(posedge clk) bus_rst <= 1'b1;
            idle(3);
            chk({7'h0, cpu_rst}, {7'h0, u[0]});
            chk({7'h0, irq}, 8'h01);
            rdc(ubs_pkg::ADDR_BUS_STAT, {u[0], 4'h0, 3'h4});
            @(posedge clk) bus_rst <= 1'b0;
            idle(3);
            chk({7'h0, cpu_rst}, 8'h00);
            rdc(ubs_pkg::ADDR_BUS_STAT, {u[0], 7'h0});
            wrr(ubs_pkg::ADDR_IRQ_STATUS, 8'h0F);
        end
        $display("test bus reset done");
        @(posedge clk) quiet <= 1'b1;
        wait_bus_suspended_flag(1'b1, cnt);
        chk({7'h0, cnt > IDLE}, 8'h01);
        chk({7'h0, irq}, 8'h01);
        rdc(ubs_pkg::ADDR_IRQ_STATUS, 8'h01);
        rdc(ubs_pkg::ADDR_BUS_STAT, 8'h01);
        wrr(ubs_pkg::ADDR_IRQ_STATUS, 8'h0F);
        @(posedge clk) quiet <= 1'b0;
        idle(3);
        rdc(ubs_pkg::ADDR_BUS_STAT, 8'h09);
        rdc(ubs_pkg::ADDR_IRQ_STATUS, 8'h04);
        @(posedge clk) quiet <= 1'b1;
        wait_bus_suspended_flag(1'b0, cnt);
        rdc(ubs_pkg::ADDR_BUS_STAT, 8'h00);
        $display("test suspend done");
        wrr(ubs_pkg::ADDR_IRQ_STATUS, 8'h0F);
        wait_bus_suspended_flag(1'b1, cnt);
        wrr(ubs_pkg::ADDR_BUS_STAT, 8'h02);
        for (cnt = 0; cnt < 400 && wake === 1'b1; cnt++) begin @(posedge clk); #1; end
        chk(cnt[7:0], WAKE[7:0]);
        wait_bus_suspended_flag(1'b0, cnt);
        @(posedge clk) quiet <= 1'b0;
        $display("test remote wake done");
        report_and_stop();
    end
endmodule // tb
